// ===== design/spi_slave_port.sv
// slave side of the synchronous serial port
// What this block does
// - shift only on master clock edges; flag once the last bit latched
// - keeps shifting during sleep; after eight bits flags and wakes
// - daisy chain: second byte out equals first byte in
// - overwrite enable accepts buffer write though transfer busy
// - mode 0100 selects slave with select pin control
// - select low with control on enables transfer and drives output
// - select high releases output at once, even mid byte
// - bit counter cleared on select high or port disable
// - full byte moves to buffer, sets full and flag; read clears full
// - write during transfer ignored, sets collision unless overwrite
// - msb first; buffer write loads shift register directly
module spi_slave_port
  import spi_slave_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       serClk,
  input  wire logic       selectN,
  input  wire logic       serDataIn,
  output logic            serDataOut,
  output logic            serDataOe,
  input  wire logic       port_enable,
  input  wire logic [3:0] portMode,
  input  wire logic       clk_idle_polarity,
  input  wire logic       clkEdgeSelect,
  input  wire logic       input_sample_phase,
  input  wire logic       buf_overwrite_en,
  input  wire logic       irqEnable,
  input  wire logic       coreSleep,
  input  wire logic       bufWrite,
  input  wire logic [7:0] bufWriteData,
  input  wire logic       bufRead,
  output logic      [7:0] data_buffer,
  output logic            buffer_full,
  output logic            write_collision,
  input  wire logic       collisionClear,
  output logic            xfer_done_irq_flag,
  input  wire logic       irqFlagClear,
  output logic            wakeRequest,
  output logic            transferActive
);
  ////////////////////////////////////////////////////////////////////////
  // pin sampling
  logic [2:0] pinSync;
  logic       sckS, ssnS, sdiS, sckPrev_reg;

  // clock folded to idle-low and select inverted, so the all-zero reset
  // state of the synchroniser matches idle pins: no false edge or select
  spi_pin_sync #(.WIDTH(3)) pinSyncInst (
    .clock   (clock),
    .rstn    (rstn),
    .pinIn   ({serClk ^ clk_idle_polarity, !selectN, serDataIn}),
    .pinSync (pinSync)
  );
  assign sckS = pinSync[2];  // high while clock is away from idle
  assign ssnS = !pinSync[1];
  assign sdiS = pinSync[0];

  ////////////////////////////////////////////////////////////////////////
  // mode and framing decode
  logic slaveSs, slaveNoSs, slaveRole, selected, frameReset;
  assign slaveSs   = port_enable && (portMode == MODE_SLAVE_SS);
  assign slaveNoSs = port_enable && (portMode == MODE_SLAVE_NOSS);
  assign slaveRole = slaveSs || slaveNoSs;
  // no select control: always selected
  assign selected  = slaveNoSs || (slaveSs && !ssnS);
  assign frameReset = !port_enable || (slaveSs && ssnS);

  ////////////////////////////////////////////////////////////////////////
  // serial clock edge detection; idle level follows polarity
  logic   sckRise, sckFall, leadEdge, trailEdge;
  edge_e  edgeKind;
  assign sckRise = sckS && !sckPrev_reg;
  assign sckFall = !sckS && sckPrev_reg;
  // leading edge leaves idle level; polarity already folded in
  assign leadEdge  = sckRise;
  assign trailEdge = sckFall;
  assign edgeKind  = leadEdge ? EDGE_LEAD :
                     (trailEdge ? EDGE_TRAIL : EDGE_NONE);

  // edge select set: output moves on trailing edge, input sampled on
  // leading; cleared: output moves on leading, input sampled on trailing
  logic sampleEdge, shiftEdge;
  assign sampleEdge = selected &&
    (clkEdgeSelect ? (edgeKind == EDGE_LEAD) : (edgeKind == EDGE_TRAIL));
  assign shiftEdge  = selected &&
    (clkEdgeSelect ? (edgeKind == EDGE_TRAIL) : (edgeKind == EDGE_LEAD));

  ////////////////////////////////////////////////////////////////////////
  // shift register and bit counter
  logic [7:0] shift_reg, shiftNext;
  logic [2:0] bitCnt_reg, bitCntNext;
  logic       outBit_reg, outBitNext;
  logic       byteDone, writeAccept, busy;

  assign busy     = selected && (bitCnt_reg != BIT_CNT_RESET);
  assign byteDone = sampleEdge && (bitCnt_reg == 3'(BITS_PER_BYTE - 1));
  // write blocked mid transfer unless overwrite on
  assign writeAccept = bufWrite && !write_collision &&
                       (!busy || buf_overwrite_en);

  // msb first in and out
  assign shiftNext  = writeAccept ? bufWriteData :
                      (sampleEdge ? {shift_reg[6:0], sdiS} : shift_reg);
  assign bitCntNext = frameReset ? BIT_CNT_RESET :
                      (sampleEdge ? bitCnt_reg + 3'h1 : bitCnt_reg);
  // buffer write puts msb at output at once
  assign outBitNext = writeAccept ? bufWriteData[7] :
                      (shiftEdge ? shift_reg[7] : outBit_reg);

  // the link logic runs off sampled pins even during core sleep
  // sleep gates nothing, so a frame in flight carries on intact
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sckPrev_reg <= 1'b0;
      shift_reg   <= BYTE_RESET;
      bitCnt_reg  <= BIT_CNT_RESET;
      outBit_reg  <= 1'b0;
    end else begin
      sckPrev_reg <= sckS;
      shift_reg   <= shiftNext;
      bitCnt_reg  <= bitCntNext;
      outBit_reg  <= outBitNext;
    end
  end

  // output driven only while selected
  assign serDataOut     = outBit_reg;
  assign serDataOe      = slaveRole && selected;
  assign transferActive = busy;

  ////////////////////////////////////////////////////////////////////////
  // buffer, status flags; set wins over clear
  logic [7:0] bufNext;
  logic       fullNext, colNext, flagNext, collide;
  assign collide  = bufWrite && !writeAccept;
  assign bufNext  = byteDone ? {shift_reg[6:0], sdiS} :
                    (writeAccept ? bufWriteData : data_buffer);
  assign fullNext = byteDone || (buffer_full && !bufRead);
  assign colNext  = collide || (write_collision && !collisionClear);
  assign flagNext = byteDone || (xfer_done_irq_flag && !irqFlagClear);

  // byteDone is formed from synchronised pins on this clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_buffer        <= BYTE_RESET;
      buffer_full        <= 1'b0;
      write_collision    <= 1'b0;
      xfer_done_irq_flag <= 1'b0;
    end else begin
      data_buffer        <= bufNext;
      buffer_full        <= fullNext;
      write_collision    <= colNext;
      xfer_done_irq_flag <= flagNext;
    end
  end

  // wake while sleeping on enabled flag
  assign wakeRequest = coreSleep && irqEnable && xfer_done_irq_flag;

  ////////////////////////////////////////////////////////////////////////
  // checks, all on the system clock
  default clocking chkClk @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence lastBitSampled;
    sampleEdge && (bitCnt_reg == 3'h7);
  endsequence

  byte_flag_a: assert property (
    lastBitSampled |=> xfer_done_irq_flag && buffer_full)
    else $error("byte end did not set flag and full");
  buf_load_a: assert property (
    lastBitSampled |=>
      data_buffer == {$past(shift_reg[6:0]), $past(sdiS)})
    else $error("buffer not loaded with received byte");
  release_out_a: assert property (
    (slaveSs && ssnS) |-> !serDataOe)
    else $error("output driven while deselected");
  drive_out_a: assert property (
    (slaveSs && !ssnS) |-> serDataOe)
    else $error("output not driven while selected");
  cnt_reset_a: assert property (
    frameReset |=> bitCnt_reg == 3'h0)
    else $error("bit counter not cleared");
  collide_a: assert property (
    (bufWrite && busy && !buf_overwrite_en) |=>
      (write_collision && $stable(shift_reg)) || $past(sampleEdge))
    else $error("blocked write not flagged");
  overwrite_a: assert property (
    (bufWrite && buf_overwrite_en && !write_collision) |=>
      shift_reg == $past(bufWriteData))
    else $error("overwrite write refused");
  no_edge_a: assert property (
    (!sampleEdge && !frameReset) |=> $stable(bitCnt_reg))
    else $error("counter moved without a clock edge");
  wake_a: assert property (
    (lastBitSampled ##1 (coreSleep && irqEnable)) |-> wakeRequest)
    else $error("no wake after byte in sleep");
  mode_a: assert property (
    (port_enable && portMode == 4'h4 && ssnS) |-> !selected)
    else $error("mode 0100 ignored select pin");

  // counting carries on whatever the core does
  sleep_count_a: assert property (
    (coreSleep && sampleEdge && !frameReset) |=>
      bitCnt_reg == $past(bitCnt_reg) + 3'h1)
    else $error("counter stalled during sleep");

  msb_load_a: assert property (
    writeAccept |=> serDataOut == $past(bufWriteData[7]))
    else $error("written msb not on output");

  col_hold_a: assert property (
    (write_collision && !collisionClear) |=> write_collision)
    else $error("collision flag dropped without clear");

  nosel_drive_a: assert property (
    slaveNoSs |-> serDataOe)
    else $error("output off with select control disabled");
endmodule

// ===== include/spi_slave_pkg.sv
// constants and types shared by the serial slave port
package spi_slave_pkg;
  localparam logic [3:0] MODE_SLAVE_SS   = 4'h4;  // slave, select pin on
  localparam logic [3:0] MODE_SLAVE_NOSS = 4'h5;  // slave, select ignored
  localparam int         BITS_PER_BYTE   = 8;
  localparam logic [2:0] BIT_CNT_RESET   = 3'h0;
  localparam logic [7:0] BYTE_RESET      = 8'h00;
  localparam int         SYNC_STAGES     = 2;
  // serial edge decode, held one-hot
  typedef enum logic [2:0] {
    EDGE_NONE  = 3'b001,
    EDGE_LEAD  = 3'b010,
    EDGE_TRAIL = 3'b100
  } edge_e;
endpackage

// ===== design/spi_pin_sync.sv
// two flip-flop synchroniser for a group of external pins
module spi_pin_sync
  import spi_slave_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] stage1_reg;

  // refuse an empty pin group at elaboration
  if (WIDTH < 1) begin : gBadWidth
    $error("spi_pin_sync: WIDTH must be positive");
  end

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage1_reg <= '0;
      pinSync    <= '0;
    end else begin
      stage1_reg <= pinIn;
      pinSync    <= stage1_reg;
    end
  end
endmodule

// ===== testbench/spi_master_model.sv
// behavioural serial master that frames and clocks transfers
module spi_master_model (
  output logic serClk,
  output logic selectN,
  output logic mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  logic idleLevel;
  // clock parked at idle low, select high between frames
  initial begin
    idleLevel = 1'b0;
    serClk = 1'b0;
    selectN = 1'b1;
    mosi = 1'b0;
  end
  // new idle level, set only while the port is disabled
  task automatic park(input logic level);
    idleLevel = level;
    serClk = level;
  endtask
  // select low, n clocks msb first, then select high;
  // data moves mid idle phase so either edge may sample it
  task automatic xfer(input int n, input logic [15:0] tx,
                      output logic [15:0] rx);
    rx = 16'h0000;
    selectN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #50 mosi = tx[i];
      #50 serClk = ~idleLevel;
      #100 rx = {rx[14:0], miso};
      serClk = idleLevel;
    end
    #100 selectN = 1'b1;
    mosi = ~mosi;  // released line keeps no stale value
  endtask
endmodule

// ===== testbench/test_spi_slave_port.sv
// self-checking bench for the serial slave port
module test_spi_slave_port
  import spi_slave_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] tx; logic [7:0] pre;} row_s;
  row_s        rows [4] = '{'{8'hA5, 8'h3C}, '{8'hFF, 8'h00},
                            '{8'h00, 8'hFF}, '{8'h81, 8'h7E}};
  logic        clock, rstn, serClk, selectN, mosi, miso, sdo, oe, en;
  logic        ovr, irqEn, sleep, wr, rd, clr, full, col, flag, wake;
  logic        pol, cke, act;
  logic [3:0]  portMode;
  logic [7:0]  wrData, dataBuf;
  logic [15:0] rx;
  int          num_errors = 0;
  int          n_compared = 0;
  ////////////////////////////////////////////////////////////////////////
  // pull-up holds the data line while the port floats it
  assign miso = oe ? sdo : 1'b1;
  spi_master_model m_u (.serClk(serClk), .selectN(selectN), .mosi(mosi),
    .miso(miso));
  spi_slave_port dut_u (.clock(clock), .rstn(rstn), .serClk(serClk),
    .selectN(selectN), .serDataIn(mosi), .serDataOut(sdo),
    .serDataOe(oe), .port_enable(en), .portMode(portMode),
    .clk_idle_polarity(pol), .clkEdgeSelect(cke),
    .input_sample_phase(1'b0), .buf_overwrite_en(ovr),
    .irqEnable(irqEn), .coreSleep(sleep), .bufWrite(wr),
    .bufWriteData(wrData), .bufRead(rd), .data_buffer(dataBuf),
    .buffer_full(full), .write_collision(col), .collisionClear(clr),
    .xfer_done_irq_flag(flag), .irqFlagClear(clr),
    .wakeRequest(wake), .transferActive(act));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  // one-clock software write, or read plus flag clear
  task automatic sw(input logic readClr, input logic [7:0] d);
    @(negedge clock);
    wrData = d;
    wr = ~readClr;
    {rd, clr} = {readClr, readClr};
    @(negedge clock);
    {wr, rd, clr} = 3'h0;
  endtask
  task automatic frame(input int n, input logic [15:0] tx);
    m_u.xfer(n, tx, rx);
    repeat (4) @(negedge clock);
  endtask
  task automatic report_and_stop();
    $display("TB: errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  // reset, table of bytes, then awkward cases
  initial begin
    {rstn, wr, rd, clr, ovr, irqEn, sleep, en} = 8'h01;
    {pol, cke} = 2'h1;
    portMode = MODE_SLAVE_SS;
    wrData = 8'h00;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    repeat (2) @(negedge clock);
    check({dataBuf, 3'h0, act, oe, full, col, flag}, 16'h0000,
      "reset");
    foreach (rows[i]) begin
      sw(1'b0, rows[i].pre);
      frame(BITS_PER_BYTE, {8'h00, rows[i].tx});
      check({dataBuf, 5'h00, full, col, flag}, {rows[i].tx, 8'h05},
        "byte in");
      check(rx, {8'h00, rows[i].pre}, "byte out");
      sw(1'b1, 8'h00);
      check({full, flag}, 16'h0000, "read clear");
    end
    frame(3, 16'h0007);
    check({oe, flag}, 16'h0000, "abort");
    frame(BITS_PER_BYTE, 16'h00C3);
    check(dataBuf, 16'h00C3, "realign");
    sw(1'b1, 8'h00);
    sw(1'b0, 8'h5A);
    fork
      m_u.xfer(BITS_PER_BYTE, 16'h0011, rx);
      begin
        #700 sw(1'b0, 8'hEE);
        check(act, 16'h0001, "busy mid byte");
      end
    join
    repeat (4) @(negedge clock);
    check({rx[7:0], 7'h00, col}, 16'h5A01, "collision");
    sw(1'b1, 8'h00);
    ovr = 1'b1;
    fork
      m_u.xfer(BITS_PER_BYTE, 16'h0022, rx);
      #700 sw(1'b0, 8'h69);
    join
    repeat (4) @(negedge clock);
    check({full, col}, 16'h0002, "overwrite");
    sw(1'b0, 8'h96);  // last byte still unread
    {ovr, sleep, irqEn} = 3'h3;
    sw(1'b1, 8'h00);
    check(wake, 16'h0000, "no wake yet");
    frame(BITS_PER_BYTE, 16'h003E);
    check({dataBuf, 7'h00, wake}, 16'h3E01, "sleep wake");
    check(rx, 16'h0096, "write kept");
    irqEn = 1'b0;
    #1 check(wake, 16'h0000, "wake gated");
    {sleep, irqEn} = 2'h0;
    sw(1'b1, 8'h00);
    frame(16, 16'hB44B);
    check({8'h00, rx[7:0]}, 16'h00B4, "daisy");
    sw(1'b1, 8'h00);
    cke = 1'b0;
    portMode = MODE_SLAVE_NOSS;
    repeat (4) @(negedge clock);
    check(oe, 16'h0001, "no select");
    frame(3, 16'h0005);
    en = 1'b0;
    pol = 1'b1;  // idle level flipped while disabled
    m_u.park(1'b1);
    @(negedge clock);
    en = 1'b1;
    frame(BITS_PER_BYTE, 16'h00D2);
    check(dataBuf, 16'h00D2, "disable");
    report_and_stop();
  end
endmodule
